//--- core/slice_cmd_defines.vh
`ifndef SLICE_CMD_DEFINES_VH
`define SLICE_CMD_DEFINES_VH
// ==========================================
// command header fields
`define CMD_TYPE_PARALLEL   3'h3
`define CMD_PIPE_DECODE     2'h2
`define CMD_OPCODE_VC1      3'h5
`define SUBOP_BUF_BASE      8'h03
`define SUBOP_SLICE_OBJ     8'h08
`define LEN_BUF_BASE        16'h0044
`define LEN_SLICE_OBJ       16'h0004
// ==========================================
// apb register byte offsets
`define REG_CMD_DATA        12'h000
`define REG_STATUS          12'h004
`define REG_PIC_CTRL        12'h008
`define REG_MEDIA_BASE      12'h00c
`define REG_DATA_OFFSET     12'h010
`define REG_BP_MB_INDEX     12'h014
`define REG_BP_ADDR         12'h018
`define REG_BP_BYTE         12'h01c
`define REG_BP_FLAGS        12'h020
`define REG_SLICE_INFO      12'h024
`define REG_FETCH_ADDR      12'h028
`define REG_FETCH_LEN       12'h02c
`define REG_CTR_SEED        12'h030
`define REG_DMV_RD          12'h034
`define REG_DMV_WR          12'h038
`define REG_DATA_WR         12'h03c
`define REG_ROW_STORE       12'h040
`define REG_CMD_WR          12'h044
`define REG_DEBLOCK         12'h048
`define REG_BP_BASE         12'h04c
`define REG_MB_SLOT         12'h050
`define REG_XFORM_DW3       12'h054
// ==========================================
// picture types in pic ctrl bits 1:0
`define PIC_I               2'h0
`define PIC_P               2'h1
`define PIC_B               2'h2
`define MB_SLOT_BYTES_RST   32'h00000400
`endif

//--- core/bitplane_nibble.v
`timescale 1ns/1ps
// ==========================================
// decode one bitplane nibble per picture type
module bitplane_nibble (
  input  wire [3:0] NIB,
  input  wire [1:0] PIC_TYPE,
  output reg  [6:0] FLAGS
);
`include "slice_cmd_defines.vh"
  // flags: overlap, ac_prediction_plane, field_transform_plane, mvtype, skip, forward, direct
  always @* begin
    FLAGS = 7'h00;
    case (PIC_TYPE)
      `PIC_P: FLAGS = {3'h0, NIB[2], NIB[1], 2'h0};
      `PIC_B: FLAGS = {4'h0, NIB[1], NIB[2], NIB[0]};
      default: FLAGS = {NIB[2], NIB[1], NIB[0], 4'h0};
    endcase
  end
endmodule

//--- core/slice_cmd_parser.v
`timescale 1ns/1ps
module slice_cmd_parser (
  input  wire        CLK,
  input  wire        RST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output reg         PSLVERR
);
`include "slice_cmd_defines.vh"
  // ==========================================
  // parser states
  localparam ST_HDR   = 4'b0001;
  localparam ST_BASE  = 4'b0010;
  localparam ST_SLICE = 4'b0100;
  localparam ST_SKIP  = 4'b1000;

  reg  [3:0]  state_q;
  reg  [15:0] left_q;
  reg  [3:0]  idx_q;
  reg  [31:0] bp_base_q;
  reg  [25:0] row_store_q;
  reg  [25:0] dmv_rd_q;
  reg  [25:0] cmd_wr_q;
  reg  [19:0] data_wr_q;
  reg  [25:0] deblock_q;
  reg  [25:0] dmv_wr_q;
  reg         base_valid_q;
  reg         encrypted_q;
  reg  [21:0] length_q;
  reg  [28:0] start_q;
  reg  [7:0]  first_row_q;
  reg  [2:0]  bit_off_q;
  reg  [7:0]  next_row_q;
  reg  [31:0] seed_q;
  reg         slice_ready_q;
  reg         hdr_err_q;
  reg         order_err_q;
  reg         mbz_err_q;
  reg  [7:0]  base_cnt_q;
  reg  [7:0]  slice_cnt_q;
  reg  [1:0]  pic_type_q;
  reg         raw_bp_q;
  reg  [6:0]  pitch_q;
  reg  [31:0] media_base_q;
  reg  [31:0] data_off_q;
  reg  [15:0] mb_index_q;
  reg  [7:0]  width_q;
  reg  [7:0]  bp_byte_q;
  reg  [31:0] slot_q;

  wire        wr_en = PSEL & PENABLE & PWRITE;
  wire        cmd_wr = wr_en & (PADDR == `REG_CMD_DATA);
  wire [31:0] d = PWDATA;

  // ==========================================
  // command header decode
  wire [2:0]  hdr_type = d[31:29];
  wire [1:0]  hdr_pipe = d[28:27];
  wire [2:0]  hdr_op   = d[26:24];
  wire [7:0]  hdr_sub  = d[23:16];
  wire [15:0] hdr_len  = d[15:0];
  // length must match exactly: a stretched command would desync the parser
  wire hdr_common = (hdr_type == `CMD_TYPE_PARALLEL) &&
                    (hdr_pipe == `CMD_PIPE_DECODE) &&
                    (hdr_op == `CMD_OPCODE_VC1);
  wire is_base  = hdr_common && (hdr_sub == `SUBOP_BUF_BASE) &&
                  (hdr_len == `LEN_BUF_BASE);
  wire is_slice = hdr_common && (hdr_sub == `SUBOP_SLICE_OBJ) &&
                  (hdr_len == `LEN_SLICE_OBJ);

  assign PREADY = 1'b1;

  // ==========================================
  // command stream parser
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q       <= ST_HDR;
      left_q        <= 16'h0000;
      idx_q         <= 4'h0;
      bp_base_q     <= 32'h00000000;
      row_store_q   <= 26'h0000000;
      dmv_rd_q      <= 26'h0000000;
      cmd_wr_q      <= 26'h0000000;
      data_wr_q     <= 20'h00000;
      deblock_q     <= 26'h0000000;
      dmv_wr_q      <= 26'h0000000;
      base_valid_q  <= 1'b0;
      encrypted_q   <= 1'b0;
      length_q      <= 22'h000000;
      start_q       <= 29'h00000000;
      first_row_q   <= 8'h00;
      bit_off_q     <= 3'h0;
      next_row_q    <= 8'h00;
      seed_q        <= 32'h00000000;
      slice_ready_q <= 1'b0;
      hdr_err_q     <= 1'b0;
      order_err_q   <= 1'b0;
      mbz_err_q     <= 1'b0;
      base_cnt_q    <= 8'h00;
      slice_cnt_q   <= 8'h00;
    end else if (cmd_wr) begin
      case (state_q)
        ST_HDR: begin
          idx_q <= 4'h1;
          if (is_base) begin
            state_q      <= ST_BASE;
            left_q       <= `LEN_BUF_BASE + 16'h0001;
            base_valid_q <= 1'b0;
          end else if (is_slice) begin
            state_q       <= ST_SLICE;
            left_q        <= `LEN_SLICE_OBJ + 16'h0001;
            slice_ready_q <= 1'b0;
            if (!base_valid_q)
              order_err_q <= 1'b1;
          end else begin
            hdr_err_q <= 1'b1;
          end
        end
        ST_BASE: begin
          case (idx_q)
            4'h1: bp_base_q   <= d;
            4'h2: row_store_q <= d[31:6];
            4'h3: dmv_rd_q    <= d[31:6];
            4'h4: cmd_wr_q    <= d[31:6];
            4'h5: data_wr_q   <= d[31:12];
            4'h6: deblock_q   <= d[31:6];
            4'h7: dmv_wr_q    <= d[31:6];
            default: ;
          endcase
          if ((idx_q == 4'h1 && d[1:0] != 2'h0) ||
              (idx_q >= 4'h2 && idx_q <= 4'h7 && d[5:0] != 6'h00))
            mbz_err_q <= 1'b1;
          if (idx_q != 4'hf)
            idx_q <= idx_q + 4'h1;
          left_q <= left_q - 16'h0001;
          if (left_q == 16'h0001) begin
            state_q      <= ST_HDR;
            base_valid_q <= 1'b1;
            base_cnt_q   <= base_cnt_q + 8'h01;
          end
        end
        ST_SLICE: begin
          case (idx_q)
            4'h1: begin
              encrypted_q <= d[31];
              length_q    <= d[21:0];
              if (d[30:22] != 9'h000)
                mbz_err_q <= 1'b1;
            end
            4'h2: begin
              start_q <= d[28:0];
              if (d[31:29] != 3'h0)
                mbz_err_q <= 1'b1;
            end
            4'h3: begin
              first_row_q <= d[31:24];
              bit_off_q   <= d[2:0];
              if (d[23:3] != 21'h000000)
                mbz_err_q <= 1'b1;
            end
            4'h4: begin
              next_row_q <= d[31:24];
              if (d[23:0] != 24'h000000)
                mbz_err_q <= 1'b1;
            end
            4'h5: seed_q     <= d;
            default: ;
          endcase
          idx_q  <= idx_q + 4'h1;
          left_q <= left_q - 16'h0001;
          if (left_q == 16'h0001) begin
            state_q       <= ST_HDR;
            slice_ready_q <= 1'b1;
            slice_cnt_q   <= slice_cnt_q + 8'h01;
          end
        end
        ST_SKIP: state_q <= ST_HDR;
        default: state_q <= ST_HDR;
      endcase
    end else if (wr_en && PADDR == `REG_STATUS) begin
      // write one to clear error flags
      if (d[1]) hdr_err_q   <= 1'b0;
      if (d[2]) order_err_q <= 1'b0;
      if (d[3]) mbz_err_q   <= 1'b0;
    end
  end

  // ==========================================
  // software-written picture context
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      pic_type_q   <= `PIC_I;
      raw_bp_q     <= 1'b0;
      pitch_q      <= 7'h00;
      width_q      <= 8'h00;
      media_base_q <= 32'h00000000;
      data_off_q   <= 32'h00000000;
      mb_index_q   <= 16'h0000;
      slot_q       <= `MB_SLOT_BYTES_RST;
      bp_byte_q    <= 8'h00;
    end else if (wr_en) begin
      case (PADDR)
        `REG_PIC_CTRL: begin
          pic_type_q <= d[1:0];
          raw_bp_q   <= d[2];
          pitch_q    <= d[14:8];
          width_q    <= d[23:16];
        end
        `REG_MEDIA_BASE:  media_base_q <= d;
        `REG_DATA_OFFSET: data_off_q   <= d;
        `REG_BP_MB_INDEX: mb_index_q   <= d[15:0];
        `REG_MB_SLOT:     slot_q       <= d;
        `REG_BP_BYTE:     bp_byte_q    <= d[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================
  // derived addresses
  wire        fetch_on  = (length_q != 22'h000000);
  wire [31:0] fetch_adr = fetch_on ?
                          media_base_q + {3'h0, start_q} :
                          32'h00000000;
  wire [31:0] data_adr  = {data_wr_q, 12'h000} + data_off_q;
  // dword 3 of generated commands excludes the data base
  wire [31:0] xform_dw3 = data_off_q;
  wire [31:0] slot_adr  = data_adr + slot_q * {16'h0000, mb_index_q};
  wire        dmv_rd_on = (pic_type_q == `PIC_B);
  wire        dmv_wr_on = (pic_type_q == `PIC_P);
  wire [31:0] seed_use  = encrypted_q ? seed_q : 32'h00000000;

  // bitplane location: row*pitch + column/2, full index width kept
  wire [15:0] div_w    = {8'h00, width_q};
  wire [15:0] col_full = (width_q == 8'h00) ? 16'h0000 :
                         mb_index_q % div_w;
  wire [15:0] row_full = (width_q == 8'h00) ? 16'h0000 :
                         mb_index_q / div_w;
  wire [7:0]  mb_col   = col_full[7:0];
  wire [7:0]  pitch_p1 = {1'b0, pitch_q} + 8'h01;
  wire [23:0] row_off  = row_full * {16'h0000, pitch_p1};
  wire [31:0] bp_adr   = bp_base_q + {8'h00, row_off} +
                         {25'h0000000, mb_col[7:1]};
  // odd column takes high nibble
  wire [3:0]  nib      = mb_col[0] ? bp_byte_q[7:4] :
                         bp_byte_q[3:0];
  wire [6:0]  flags;

  bitplane_nibble u_nibble (
    .NIB      (nib),
    .PIC_TYPE (pic_type_q),
    .FLAGS    (flags)
  );

  // raw bitplanes come from the bitstream, buffer unused
  wire [6:0] flags_use = raw_bp_q ? 7'h00 : flags;

  // ==========================================
  // apb read mux
  reg  [31:0] rdata_d;
  reg         slverr_d;

  always @* begin
    rdata_d  = 32'h00000000;
    slverr_d = 1'b0;
    case (PADDR)
      `REG_CMD_DATA:    rdata_d = 32'h00000000;
      `REG_STATUS:      rdata_d = {8'h00, slice_cnt_q, base_cnt_q,
                                   state_q, mbz_err_q, order_err_q,
                                   hdr_err_q, slice_ready_q};
      `REG_PIC_CTRL:    rdata_d = {8'h00, width_q, 1'b0, pitch_q,
                                   5'h00, raw_bp_q, pic_type_q};
      `REG_MEDIA_BASE:  rdata_d = media_base_q;
      `REG_DATA_OFFSET: rdata_d = data_off_q;
      `REG_BP_MB_INDEX: rdata_d = {16'h0000, mb_index_q};
      `REG_BP_ADDR:     rdata_d = bp_adr;
      `REG_BP_BYTE:     rdata_d = {24'h000000, bp_byte_q};
      `REG_BP_FLAGS:    rdata_d = {25'h0000000, flags_use};
      `REG_SLICE_INFO:  rdata_d = {first_row_q, next_row_q, 4'h0,
                                   bit_off_q, encrypted_q, 6'h00,
                                   fetch_on, 1'b0};
      `REG_FETCH_ADDR:  rdata_d = fetch_adr;
      `REG_FETCH_LEN:   rdata_d = {10'h000, length_q};
      `REG_CTR_SEED:    rdata_d = seed_use;
      `REG_DMV_RD:      rdata_d = dmv_rd_on ? {dmv_rd_q, 6'h00} : 32'h0;
      `REG_DMV_WR:      rdata_d = dmv_wr_on ? {dmv_wr_q, 6'h00} : 32'h0;
      `REG_DATA_WR:     rdata_d = data_adr;
      `REG_ROW_STORE:   rdata_d = {row_store_q, 6'h00};
      `REG_CMD_WR:      rdata_d = {cmd_wr_q, 6'h00};
      `REG_DEBLOCK:     rdata_d = {deblock_q, 6'h00};
      `REG_BP_BASE:     rdata_d = bp_base_q;
      `REG_MB_SLOT:     rdata_d = slot_adr;
      `REG_XFORM_DW3:   rdata_d = xform_dw3;
      default:          slverr_d = 1'b1;
    endcase
  end

  // ==========================================
  // read data captured at setup so it stands through the access phase
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA  <= rdata_d;
      PSLVERR <= slverr_d;
    end else if (PSEL && !PENABLE) begin
      PSLVERR <= 1'b0;
    end
  end
endmodule

//--- dv/slice_cmd_parser_sva.sv
`timescale 1ns/1ps
`include "slice_cmd_defines.vh"
// ==========================================
// apb port checker for the slice command parser
module slice_cmd_parser_sva (
  input wire        CLK,
  input wire        RST,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        PSLVERR
);
  reg  [1:0]  pic_type_q;
  reg         raw_q;
  reg  [31:0] offset_q;
  reg         len_zero_q;
  reg         enc_q;
  wire        wr_acc = PSEL & PENABLE & PWRITE;
  wire        rd_acc = PSEL & PENABLE & ~PWRITE;
  // shadows of host writes and of the last slice readbacks
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      pic_type_q <= 2'h0;
      raw_q      <= 1'b0;
      offset_q   <= 32'h0;
      len_zero_q <= 1'b1;
      enc_q      <= 1'b0;
    end else begin
      if (wr_acc && PADDR == `REG_PIC_CTRL) begin
        pic_type_q <= PWDATA[1:0];
        raw_q      <= PWDATA[2];
      end
      if (wr_acc && PADDR == `REG_DATA_OFFSET)
        offset_q <= PWDATA;
      if (rd_acc && PADDR == `REG_FETCH_LEN)
        len_zero_q <= (PRDATA[21:0] == 22'h0);
      if (rd_acc && PADDR == `REG_SLICE_INFO)
        enc_q <= PRDATA[8];
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence rd_at(logic [11:0] a);
    PSEL && PENABLE && !PWRITE && PADDR == a;
  endsequence
  dmv_rd_gate_a: assert property (rd_at(`REG_DMV_RD) ##0
    pic_type_q != `PIC_B |-> PRDATA == 32'h0) else $error("dmv read leak");
  dmv_wr_gate_a: assert property (rd_at(`REG_DMV_WR) ##0
    pic_type_q != `PIC_P |-> PRDATA == 32'h0) else $error("dmv write leak");
  xform_dw3_a: assert property (rd_at(`REG_XFORM_DW3)
    |-> PRDATA == offset_q) else $error("dw3 not offset");
  flag_width_a: assert property (rd_at(`REG_BP_FLAGS)
    |-> PRDATA[31:7] == 25'h0) else $error("flag bits high");
  raw_flags_a: assert property (rd_at(`REG_BP_FLAGS) ##0 raw_q
    |-> PRDATA == 32'h0) else $error("raw flags not zero");
  len_width_a: assert property (rd_at(`REG_FETCH_LEN)
    |-> PRDATA[31:22] == 10'h0) else $error("length too wide");
  fetch_off_a: assert property (rd_at(`REG_FETCH_ADDR) ##0 len_zero_q
    |-> PRDATA == 32'h0) else $error("fetch with zero length");
  seed_plain_a: assert property (rd_at(`REG_CTR_SEED) ##0 !enc_q
    |-> PRDATA == 32'h0) else $error("seed not ignored");
  unmapped_err_a: assert property (rd_acc && PADDR > `REG_XFORM_DW3
    |-> PSLVERR) else $error("no error on unmapped read");
  mapped_ok_a: assert property (PSEL && PENABLE && (PWRITE ||
    (PADDR <= `REG_XFORM_DW3 && PADDR[1:0] == 2'h0)) |-> !PSLVERR)
    else $error("bad error");
  rdata_hold_a: assert property (rd_acc ##1 !PSEL
    |-> $stable(PRDATA)) else $error("read data dropped");
endmodule
bind slice_cmd_parser slice_cmd_parser_sva chk (.CLK(CLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

//--- dv/cmd_streamer.sv
`timescale 1ns/1ps
// ==========================================
// command streamer model: apb master feeding command dwords
module cmd_streamer (
  input  wire        CLK,
  output reg         PSEL,
  output reg         PENABLE,
  output reg         PWRITE,
  output reg  [11:0] PADDR,
  output reg  [31:0] PWDATA,
  input  wire [31:0] PRDATA,
  input  wire        PREADY,
  input  wire        PSLVERR
);
  reg [31:0] rd_q;
  reg        err_q;
  reg [31:0] pay [1:7];
  integer    i;
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h0;
    PWDATA = 32'h0;
  end
  // request held until pready is seen high, then released
  task xfer(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      @(posedge CLK);
      while (!PREADY) @(posedge CLK);
      rd_q = PRDATA;
      err_q = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
    end
  endtask
  // header then 0x45 dwords; words past dword 7 carry zero
  task send_base(input [31:0] d1, d2, d3, d4, d5, d6, d7);
    begin
      pay[1] = d1; pay[2] = d2; pay[3] = d3; pay[4] = d4;
      pay[5] = d5; pay[6] = d6; pay[7] = d7;
      xfer(1'b1, 12'h000, 32'h75030044);
      for (i = 1; i <= 69; i = i + 1)
        xfer(1'b1, 12'h000, i <= 7 ? pay[i] : 32'h0);
    end
  endtask
  task send_slice(input [31:0] d1, d2, d3, d4, d5);
    begin
      xfer(1'b1, 12'h000, 32'h75080004);
      xfer(1'b1, 12'h000, d1);
      xfer(1'b1, 12'h000, d2);
      xfer(1'b1, 12'h000, d3);
      xfer(1'b1, 12'h000, d4);
      xfer(1'b1, 12'h000, d5);
    end
  endtask
endmodule

//--- dv/vc1_slice_decode_cmd_parser_bench.sv
`timescale 1ns/1ps
`include "slice_cmd_defines.vh"
module vc1_slice_decode_cmd_parser_bench;
  reg         CLK, RST;
  wire        psel, penable, pwrite, pready, pslverr;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  integer     num_errors, total_checks, cycles, t, w, p, idx, row, col;
  reg  [15:0] lfsr_q;
  reg  [31:0] bp, s2, s3, s5, s7, off, slot, media, len, adr, seed, b, x;
  cmd_streamer cs (.CLK(CLK), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr));
  slice_cmd_parser dut (.CLK(CLK), .RST(RST), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  function [31:0] rnd(input integer dummy);
    integer k;
    begin
      for (k = 0; k < 32; k = k + 1) begin
        lfsr_q = {lfsr_q[14:0], lfsr_q[15]^lfsr_q[13]^lfsr_q[12]^lfsr_q[10]};
        rnd[k] = lfsr_q[0];
      end
    end
  endfunction
  function [31:0] flags(input integer ty, input [3:0] n);
    flags = ty == 0 ? {25'h0, n[2:0], 4'h0} :
            ty == 1 ? {28'h0, n[2:1], 2'h0} : {29'h0, n[1], n[2], n[0]};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task rd(input [11:0] a);
    cs.xfer(1'b0, a, 32'h0);
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  // hang guard, far above the roughly 1200 cycles the run needs
  always @(posedge CLK) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      final_report;
    end
  end
  initial begin
    RST = 1'b1;
    num_errors = 0;
    total_checks = 0;
    cycles = 0;
    lfsr_q = 16'd24632;
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    rd(`REG_STATUS);
    chk(cs.rd_q & 32'h00ffff0f, 32'h0);
    cs.send_slice(32'h0, 32'h0, 32'h0, 32'h1, 32'h0);
    rd(`REG_STATUS);
    chk(cs.rd_q & 32'hc, 32'hc);
    cs.xfer(1'b1, `REG_STATUS, 32'he);
    cs.xfer(1'b1, `REG_CMD_DATA, 32'h75070044);
    rd(`REG_STATUS);
    chk(cs.rd_q & 32'h2, 32'h2);
    cs.send_base(32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0);
    rd(`REG_STATUS);
    chk(cs.rd_q & 32'h8, 32'h8);
    cs.xfer(1'b1, `REG_STATUS, 32'he);
    for (t = 0; t < 3; t = t + 1) begin
      // each pass is a new stream, so every base is reissued
      bp = rnd(0) & ~32'h3;
      s2 = rnd(0) & ~32'h3f;
      s3 = rnd(0) & ~32'h3f;
      s5 = rnd(0) & 32'hfffff000;
      s7 = rnd(0) & ~32'h3f;
      cs.send_base(bp, s2, s3, s2 ^ 32'h40, s5, s3 ^ 32'h80, s7);
      rd(`REG_STATUS);
      chk(cs.rd_q & 32'he, 32'h0);
      rd(`REG_BP_BASE);
      chk(cs.rd_q, bp);
      rd(`REG_ROW_STORE);
      chk(cs.rd_q, s2);
      rd(`REG_CMD_WR);
      chk(cs.rd_q, s2 ^ 32'h40);
      rd(`REG_DEBLOCK);
      chk(cs.rd_q, s3 ^ 32'h80);
      w = (rnd(0) % 45) | 1;
      p = w / 2 + 1 + rnd(0) % 4;
      x = {8'h0, w[7:0], 1'b0, p[6:0] - 7'h1, 6'h0, t[1:0]};
      cs.xfer(1'b1, `REG_PIC_CTRL, x);
      rd(`REG_DMV_RD);
      chk(cs.rd_q, t == 2 ? s3 : 32'h0);
      rd(`REG_DMV_WR);
      chk(cs.rd_q, t == 1 ? s7 : 32'h0);
      off = rnd(0) & 32'hfff;
      cs.xfer(1'b1, `REG_DATA_OFFSET, off);
      rd(`REG_DATA_WR);
      chk(cs.rd_q, s5 + off);
      rd(`REG_XFORM_DW3);
      chk(cs.rd_q, off);
      row = rnd(0) % 4;
      col = t == 2 ? w - 1 : rnd(0) % w;
      idx = row * w + col;
      slot = (rnd(0) & 32'h3c0) + 32'h40;
      cs.xfer(1'b1, `REG_MB_SLOT, slot);
      cs.xfer(1'b1, `REG_BP_MB_INDEX, idx);
      rd(`REG_MB_SLOT);
      chk(cs.rd_q, s5 + off + slot * idx);
      rd(`REG_BP_ADDR);
      chk(cs.rd_q, bp + row * p + col / 2);
      b = rnd(0) & 32'h77;
      cs.xfer(1'b1, `REG_BP_BYTE, b);
      rd(`REG_BP_FLAGS);
      chk(cs.rd_q, flags(t, col % 2 ? b[7:4] : b[3:0]));
      cs.xfer(1'b1, `REG_PIC_CTRL, x | 32'h4);
      rd(`REG_BP_FLAGS);
      chk(cs.rd_q, 32'h0);
      media = rnd(0);
      cs.xfer(1'b1, `REG_MEDIA_BASE, media);
      len = t == 0 ? 32'h0 : rnd(0) & 32'h3fffff;
      adr = rnd(0) & (t == 1 ? 32'h1ffffff0 : 32'h1fffffff);
      x = rnd(0);
      seed = rnd(0);
      cs.send_slice({t == 1, 9'h0, len[21:0]}, adr, x & 32'hff000007,
        {x[23:16], 24'h0}, seed);
      rd(`REG_SLICE_INFO);
      chk(cs.rd_q & 32'hffff0f02, {x[31:24], x[23:16], 4'h0, x[2:0],
        t == 1, 6'h0, len != 0, 1'b0});
      rd(`REG_FETCH_LEN);
      chk(cs.rd_q, len);
      rd(`REG_FETCH_ADDR);
      chk(cs.rd_q, len != 0 ? media + adr : 32'h0);
      rd(`REG_CTR_SEED);
      chk(cs.rd_q, t == 1 ? seed : 32'h0);
      rd(`REG_STATUS);
      chk(cs.rd_q & 32'he, 32'h0);
    end
    cs.xfer(1'b1, 12'h0fc, 32'h1);
    chk({31'h0, cs.err_q}, 32'h0);
    rd(12'h0fc);
    chk({31'h0, cs.err_q}, 32'h1);
    @(posedge CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    rd(`REG_STATUS);
    chk(cs.rd_q & 32'h00ffff0f, 32'h0);
    final_report;
  end
endmodule
